// ### core/sqc_pkg.sv
// Package with the step-6 configuration register layout and decode constants
// Operation
// - Bit 15 enables step 6 in the sequence; resets to 0.
// - Bits 14:13 select gain: 00 gives 1, 01 gives 2, 10/11 give 4.
// - Bits 12:5 are reserved, read as zero whatever is written.
// - Bit 4 picks negative input: 0 analog ground, 1 analog input 7.
// - Bits 3:0 codes 0-7 pick external inputs 0-7; reset code 6.
// - Codes 8-15 are internal sources; negative input chosen automatically.
// - Code 9 shorts converter input to ground, all external pins off.
// - Register sits at address 96h with reset value 0006h.
package sqc_pkg;
  localparam logic [7:0]  SQC_STEP6_ADDR    = 8'h96;
  localparam logic [15:0] SQC_STEP6_RESET   = 16'h0006;
  localparam int          SQC_EN_BIT        = 15;
  localparam int          SQC_GAIN_HI       = 14;
  localparam int          SQC_GAIN_LO       = 13;
  localparam int          SQC_NEG_BIT       = 4;
  localparam int          SQC_POS_HI        = 3;
  localparam int          SQC_POS_LO        = 0;
  localparam logic [15:0] SQC_WRITE_MASK    = 16'hE01F;
  localparam logic [3:0]  SQC_POS_SHORT     = 4'h9;
  localparam logic [2:0]  SQC_GAIN_X1       = 3'h1;
  localparam logic [2:0]  SQC_GAIN_X2       = 3'h2;
  localparam logic [2:0]  SQC_GAIN_X4       = 3'h4;

  typedef enum logic [1:0] {
    SQC_NEG_GROUND,
    SQC_NEG_INPUT7,
    SQC_NEG_AUTO
  } sqc_neg_t;
endpackage

// ### core/sqc_decode_if.sv
// Interface carrying the stored step-6 word to the decoder and its results
`timescale 1ns/1ps
interface sqc_decode_if;
  logic [15:0] word;
  logic        step_enable;
  logic [2:0]  gain;
  logic [1:0]  neg_sel;
  logic        pos_external;
  logic [2:0]  pos_input;
  logic        ground_short;
  logic [3:0]  internal_src;

  modport store
  (
    output word,
    input  step_enable, gain, neg_sel, pos_external, pos_input,
    input  ground_short, internal_src
  );
  modport decode
  (
    input  word,
    output step_enable, gain, neg_sel, pos_external, pos_input,
    output ground_short, internal_src
  );
endinterface // sqc_decode_if

// ### core/sqc_decode.sv
// Combinational decode of the step-6 word into converter controls
`timescale 1ns/1ps
module sqc_decode
  import sqc_pkg::*;
(
  sqc_decode_if.decode dec
);
  logic [3:0] pos_code;

  assign pos_code = dec.word[SQC_POS_HI:SQC_POS_LO];

  always_comb
  begin
    dec.step_enable = dec.word[SQC_EN_BIT];
    case (dec.word[SQC_GAIN_HI:SQC_GAIN_LO])
      2'h0:    dec.gain = SQC_GAIN_X1;
      2'h1:    dec.gain = SQC_GAIN_X2;
      default: dec.gain = SQC_GAIN_X4;
    endcase
  end

  always_comb
  begin
    dec.pos_external = ~pos_code[3];
    dec.pos_input    = pos_code[2:0];
    dec.ground_short = (pos_code == SQC_POS_SHORT);
    dec.internal_src = pos_code;
    if (pos_code[3])
    begin
      // Internal sources pair with their own return; the select bit is moot
      dec.neg_sel = SQC_NEG_AUTO;
    end
    else if (dec.word[SQC_NEG_BIT])
    begin
      dec.neg_sel = SQC_NEG_INPUT7;
    end
    else
    begin
      dec.neg_sel = SQC_NEG_GROUND;
    end
  end
endmodule // sqc_decode

// ### core/sqc_step6_config.sv
// Step-6 sequencer configuration register with decoded converter controls
`timescale 1ns/1ps
module sqc_step6_config
  import sqc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_write_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic [15:0]      reg_rdata_out,
  output logic             seq_step6_enable_out,
  output logic [2:0]       seq_step6_gain_out,
  output logic [1:0]       seq_step6_neg_sel_out,
  output logic             seq_step6_pos_external_out,
  output logic [2:0]       seq_step6_pos_input_out,
  output logic             seq_step6_ground_short_out,
  output logic [3:0]       seq_step6_internal_src_out
);
  // Field values after reset, cut from the reset word of the register
  localparam logic       RST_ENABLE = SQC_STEP6_RESET[SQC_EN_BIT];
  localparam logic [1:0] RST_GAIN   =
    SQC_STEP6_RESET[SQC_GAIN_HI:SQC_GAIN_LO];
  localparam logic       RST_NEG    = SQC_STEP6_RESET[SQC_NEG_BIT];
  localparam logic [3:0] RST_POS    =
    SQC_STEP6_RESET[SQC_POS_HI:SQC_POS_LO];

  // Decoded controls after reset follow from the reset positive code
  localparam logic       RST_POS_EXTERNAL = ~RST_POS[3];
  localparam logic [2:0] RST_POS_INPUT    = RST_POS[2:0];
  localparam logic       RST_SHORT        = (RST_POS == SQC_POS_SHORT);

  // Only the writable fields have flops; the reserved span has none
  logic         seq_step6_enable;
  logic [1:0]   seq_step6_gain_select;
  logic         seq_step6_neg_input_select;
  logic [3:0]   seq_step6_pos_input_select;
  logic [15:0]  seq_step6_config;
  logic         hit;
  logic         wr_hit;
  sqc_decode_if dec_if ();

  assign hit    = (reg_addr_in == SQC_STEP6_ADDR);
  assign wr_hit = reg_write_in && hit;

  // Step enable; a write elsewhere leaves every field alone
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_enable <= RST_ENABLE;
    end
    else if (wr_hit)
    begin
      seq_step6_enable <= reg_wdata_in[SQC_EN_BIT];
    end
  end

  // Gain code is kept raw; both upper codes mean gain 4 downstream
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_gain_select <= RST_GAIN;
    end
    else if (wr_hit)
    begin
      seq_step6_gain_select <= reg_wdata_in[SQC_GAIN_HI:SQC_GAIN_LO];
    end
  end

  // Negative select is stored even when an internal code makes it moot
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_neg_input_select <= RST_NEG;
    end
    else if (wr_hit)
    begin
      seq_step6_neg_input_select <= reg_wdata_in[SQC_NEG_BIT];
    end
  end

  // Positive input code, external and internal sources alike
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_pos_input_select <= RST_POS;
    end
    else if (wr_hit)
    begin
      seq_step6_pos_input_select <= reg_wdata_in[SQC_POS_HI:SQC_POS_LO];
    end
  end

  // Reserved bits are tied low in the word, so they can never read back
  assign seq_step6_config = {seq_step6_enable, seq_step6_gain_select,
                             8'h00, seq_step6_neg_input_select,
                             seq_step6_pos_input_select};
  assign dec_if.word      = seq_step6_config;

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      reg_rdata_out <= 16'h0000;
    end
    else if (hit)
    begin
      reg_rdata_out <= seq_step6_config & SQC_WRITE_MASK;
    end
    else
    begin
      reg_rdata_out <= 16'h0000;
    end
  end

  sqc_decode u_decode
  (
    .dec (dec_if.decode)
  );

  // Controls lag the stored word by one cycle to keep outputs registered
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_enable_out <= RST_ENABLE;
    end
    else
    begin
      seq_step6_enable_out <= dec_if.step_enable;
    end
  end

  // Gain leaves as a one-hot-like factor so the converter needs no decode
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_gain_out <= SQC_GAIN_X1;
    end
    else
    begin
      seq_step6_gain_out <= dec_if.gain;
    end
  end

  // The automatic choice wins over the stored select bit
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_neg_sel_out <= SQC_NEG_GROUND;
    end
    else
    begin
      seq_step6_neg_sel_out <= dec_if.neg_sel;
    end
  end

  // Low for every internal code, which keeps the pins off during a short
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_pos_external_out <= RST_POS_EXTERNAL;
    end
    else
    begin
      seq_step6_pos_external_out <= dec_if.pos_external;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_pos_input_out <= RST_POS_INPUT;
    end
    else
    begin
      seq_step6_pos_input_out <= dec_if.pos_input;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_ground_short_out <= RST_SHORT;
    end
    else
    begin
      seq_step6_ground_short_out <= dec_if.ground_short;
    end
  end

  // Raw code passes through so the sequencer can pick the internal source
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_step6_internal_src_out <= RST_POS;
    end
    else
    begin
      seq_step6_internal_src_out <= dec_if.internal_src;
    end
  end
endmodule // sqc_step6_config

// ### dv/sqc_step6_checker.sv
// Checker for the step-6 configuration register
`timescale 1ns/1ps
module sqc_step6_checker
  import sqc_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        reg_write_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        seq_step6_enable_out,
  input wire logic        seq_step6_ground_short_out,
  input wire logic        seq_step6_pos_external_out,
  input wire logic [2:0]  seq_step6_gain_out,
  input wire logic [2:0]  seq_step6_pos_input_out,
  input wire logic [1:0]  seq_step6_neg_sel_out,
  input wire logic [3:0]  seq_step6_internal_src_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic        wr;
  logic [15:0] d1, d2;
  assign wr = reg_write_in && reg_addr_in == SQC_STEP6_ADDR;
  // Write data two edges back lines up with the decoded outputs
  always_ff @(posedge clk_in)
  begin
    d1 <= reg_wdata_in;
    d2 <= d1;
  end
  AST_EN: assert property (wr |-> ##2 seq_step6_enable_out == d2[15])
    else $error("enable");
  AST_GAIN: assert property (wr |-> ##2
    seq_step6_gain_out == (d2[14] ? 3'h4 : d2[13] ? 3'h2 : 3'h1))
    else $error("gain");
  AST_RSV: assert property (reg_rdata_out[12:5] == 8'h00)
    else $error("reserved");
  AST_NEG: assert property (wr && !reg_wdata_in[3] |-> ##2
    seq_step6_neg_sel_out == {1'h0, d2[4]}) else $error("neg");
  AST_POS: assert property (wr && !reg_wdata_in[3] |-> ##2
    seq_step6_pos_external_out && seq_step6_pos_input_out == d2[2:0])
    else $error("pos");
  AST_AUTO: assert property (wr && reg_wdata_in[3] |-> ##2
    seq_step6_neg_sel_out == 2'h2 && !seq_step6_pos_external_out)
    else $error("auto");
  AST_SRC: assert property (wr |-> ##2
    seq_step6_internal_src_out == d2[3:0]) else $error("source");
  AST_SHORT: assert property (wr |-> ##2
    seq_step6_ground_short_out == ($past(reg_wdata_in[3:0], 2) == 4'h9))
    else $error("short");
  AST_READ: assert property (wr ##1 !reg_write_in &&
    reg_addr_in == SQC_STEP6_ADDR |=> reg_rdata_out == (d2 & 16'hE01F))
    else $error("read");
  cover property (wr && reg_wdata_in[3:0] == 4'h9);
  cover property (wr && reg_wdata_in[14:13] == 2'h3);
  cover property (wr && reg_wdata_in[15]);
endmodule // sqc_step6_checker
bind sqc_step6_config sqc_step6_checker i_sqc_step6_checker (.*);

// ### dv/tb_top.sv
// Self-checking bench for the step-6 configuration register
`timescale 1ns/1ps
module tb_top;
  import sqc_pkg::*;
  logic        clk_in = 1'h0, rst_b_in = 1'h0, we = 1'h0, en, ex, sh;
  logic [7:0]  ad = 8'h96;
  logic [15:0] wd = 16'h0000, rd, d;
  logic [2:0]  gn, pi;
  logic [1:0]  ns;
  logic [3:0]  src;
  int n_mismatch = 0, check_count = 0;
  always #2.5 clk_in = ~clk_in;
  sqc_step6_config i_sqc_step6_config (.clk_in, .rst_b_in, .reg_addr_in(ad),
    .reg_write_in(we), .reg_wdata_in(wd), .reg_rdata_out(rd),
    .seq_step6_enable_out(en), .seq_step6_gain_out(gn),
    .seq_step6_neg_sel_out(ns), .seq_step6_pos_external_out(ex),
    .seq_step6_pos_input_out(pi), .seq_step6_ground_short_out(sh),
    .seq_step6_internal_src_out(src));
  task chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Leaves the address on the word so the read-back lands after the decode
  task put(input logic [7:0] a, input logic [15:0] v);
    ad = a;
    wd = v;
    we = 1'h1;
    @(negedge clk_in);
    we = 1'h0;
    ad = 8'h96;
    @(negedge clk_in);
    @(negedge clk_in);
  endtask
  task t_reset;
    chk(rd, 16'h0006);
    chk({en, gn, ns, ex, pi, sh}, {1'h0, 3'h1, 2'h0, 1'h1, 3'h6, 1'h0});
    chk(src, 4'h6);
  endtask
  // A reset in mid-run must bring the defaults back over a written word
  task t_mid_reset;
    put(8'h96, 16'hE01F);
    rst_b_in = 1'h0;
    @(negedge clk_in);
    chk(rd, 16'h0000);
    chk(src, 4'h6);
    rst_b_in = 1'h1;
    @(negedge clk_in);
    t_reset;
  endtask
  // Every positive code, every gain code, both negative selections
  task t_sweep;
    for (int i = 0; i < 16; i++)
    begin
      d = {i[0], i[1:0], 8'hFF, ~i[1], i[3:0]};
      put(8'h96, d);
      chk(rd, {d[15:13], 8'h00, d[4:0]});
      chk(en, d[15]);
      chk(gn, d[14] ? 3'h4 : (d[13] ? 3'h2 : 3'h1));
      chk(ns, d[3] ? 2'h2 : {1'h0, d[4]});
      chk({ex, sh, src}, {~d[3], d[3:0] == 4'h9, d[3:0]});
      if (!d[3])
        chk(pi, d[2:0]);
    end
  endtask
  task t_unmapped;
    put(8'h96, 16'h8013);
    put(8'h95, 16'h7FEC);
    chk(rd, 16'h8013);
    chk({en, src}, {1'h1, 4'h3});
    ad = 8'h95;
    @(negedge clk_in);
    chk(rd, 16'h0000);
  endtask
  initial
  begin
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'h1;
    @(negedge clk_in);
    t_reset;
    t_sweep;
    t_unmapped;
    t_mid_reset;
    print_verdict;
  end
  initial
  begin
    #2000;
    n_mismatch++;
    print_verdict;
  end
endmodule // tb_top
